// ==== hw/mac_cipher_path_command.sv ====
// Cipher start and path on/off command registers with a classic Wishbone slave
// Contract
// [RULE_01] Decrypt start bit set to one decrypts RX FIFO data back into it.
// [RULE_02] Encrypt start bit set to one encrypts the TX FIFO data.
// [RULE_03] Encrypted TX data replaces the plain data in the TX FIFO.
// [RULE_04] Completion of either operation raises an interrupt.
// [RULE_05] Hardware leaves the start bit set; software must clear it.
// [RULE_06] Transmit on low with transmit off high keeps modulation disabled; off resets high.
// [RULE_07] Receive on low with receive off high keeps demodulation disabled; off resets high.
// [RULE_08] On forces enable, off alone disables, both low leaves it to the modem.
// [RULE_09] A start bit left set never retriggers; clear and set again to restart.
`timescale 1ns/1ps
`include "mac_cipher_cfg.svh"
module mac_cipher_path_command
  import mac_cipher_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic dec_done_i,
  input wire logic enc_done_i,
  input wire logic modem_tx_req_i,
  input wire logic modem_rx_req_i,
  output cipher_req_s cipher_req_o,
  output path_en_s path_en_o,
  output logic irq_o
);

  typedef struct packed {
    logic cmd_dec;
    logic cmd_enc;
    logic cmd_transmit_path_off;
    logic cmd_receive_path_off;
    logic [1:0] path_on;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic ack;
    logic [7:0] rdata;
    logic mod_en;
    logic demod_en;
    logic irq;
  } regs_s;

  regs_s r;
  regs_s r_next;

  logic dec_go;
  logic enc_go;
  logic dec_busy;
  logic enc_busy;
  logic dec_spent;
  logic enc_spent;
  logic dec_complete;
  logic enc_complete;
  logic tx_en;
  logic rx_en;
  logic acc;
  logic wr;
  logic wr_cmd;
  logic wr_sts;
  logic [1:0] evt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] a, input regs_s rr,
                                        input logic [1:0] busy);
    rd_mux = 8'h00;
    if (hit(a, `CMD_OFS)) begin
      rd_mux = {`CMD_RSVD_HI, rr.cmd_dec, rr.cmd_enc,
                `CMD_RSVD_LO, rr.cmd_transmit_path_off, rr.cmd_receive_path_off};
    end else if (hit(a, `PATH_ON_OFS)) begin
      rd_mux = {6'h00, rr.path_on};
    end else if (hit(a, `IRQ_STS_OFS)) begin
      rd_mux = {6'h00, rr.irq_sts};
    end else if (hit(a, `IRQ_MSK_OFS)) begin
      rd_mux = {6'h00, rr.irq_msk};
    end else if (hit(a, `ENGINE_STS_OFS)) begin
      rd_mux = {6'h00, busy};
    end
  endfunction

  cipher_op_seq u_dec_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_bit_i(r.cmd_dec),
    .done_i(dec_done_i),
    .go_o(dec_go),
    .busy_o(dec_busy),
    .spent_o(dec_spent),
    .complete_o(dec_complete)
  );

  cipher_op_seq u_enc_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_bit_i(r.cmd_enc),
    .done_i(enc_done_i),
    .go_o(enc_go),
    .busy_o(enc_busy),
    .spent_o(enc_spent),
    .complete_o(enc_complete)
  );

  path_gate u_tx_gate (
    .on_i(r.path_on[`TRANSMIT_PATH_ON_BIT]),
    .off_i(r.cmd_transmit_path_off),
    .modem_i(modem_tx_req_i),
    .en_o(tx_en)
  );

  path_gate u_rx_gate (
    .on_i(r.path_on[`RECEIVE_PATH_ON_BIT]),
    .off_i(r.cmd_receive_path_off),
    .modem_i(modem_rx_req_i),
    .en_o(rx_en)
  );

  // Writes land on the edge that ends the ack cycle, when the master samples it
  assign acc = cyc_i & stb_i;
  assign wr = acc & r.ack & we_i & sel_i[0];
  assign wr_cmd = wr & hit(adr_i, `CMD_OFS);
  assign wr_sts = wr & hit(adr_i, `IRQ_STS_OFS);

  always_comb begin
    evt = 2'h0;
    evt[`IRQ_DEC_BIT] = dec_complete; // [RULE_04]
    evt[`IRQ_ENC_BIT] = enc_complete; // [RULE_04]
  end

  always_comb begin
    r_next = r;
    r_next.ack = 1'b0;
    if (acc && !r.ack) begin
      r_next.ack = 1'b1;
      r_next.rdata = rd_mux(adr_i, r, {enc_busy, dec_busy});
    end
    if (wr_cmd) begin
      // Start bits change only by software; completion leaves them alone
      r_next.cmd_dec = dat_i[`CMD_DEC_BIT]; // [RULE_05]
      r_next.cmd_enc = dat_i[`CMD_ENC_BIT]; // [RULE_05]
      r_next.cmd_transmit_path_off = dat_i[`CMD_TRANSMIT_PATH_OFF_BIT];
      r_next.cmd_receive_path_off = dat_i[`CMD_RECEIVE_PATH_OFF_BIT];
    end
    if (wr && hit(adr_i, `PATH_ON_OFS)) begin
      r_next.path_on = dat_i[1:0];
    end
    if (wr && hit(adr_i, `IRQ_MSK_OFS)) begin
      r_next.irq_msk = dat_i[1:0];
    end
    // Write one to clear; a completion in the same cycle still sets the bit
    if (wr_sts) begin
      r_next.irq_sts = (r.irq_sts & ~dat_i[1:0]) | evt; // [RULE_04]
    end else begin
      r_next.irq_sts = r.irq_sts | evt; // [RULE_04]
    end
    r_next.irq = |(r_next.irq_sts & r_next.irq_msk);
    r_next.mod_en = tx_en; // [RULE_06]
    r_next.demod_en = rx_en; // [RULE_07]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '{cmd_dec: 1'b0, cmd_enc: 1'b0,
             cmd_transmit_path_off: `CMD_TRANSMIT_PATH_OFF_RESET, cmd_receive_path_off: `CMD_RECEIVE_PATH_OFF_RESET,
             path_on: `PATH_ON_RESET, irq_sts: `IRQ_RESET,
             irq_msk: `IRQ_RESET, ack: 1'b0, rdata: 8'h00,
             mod_en: 1'b0, demod_en: 1'b0, irq: 1'b0};
    end else begin
      r <= r_next;
    end
  end

  assign ack_o = r.ack;
  assign dat_o = {24'h000000, r.rdata};
  assign irq_o = r.irq;
  assign path_en_o.mod_en = r.mod_en;
  assign path_en_o.demod_en = r.demod_en;
  assign cipher_req_o.decrypt_go = dec_go; // [RULE_01]
  assign cipher_req_o.encrypt_go = enc_go; // [RULE_02]
  // The core always writes its result over the source data in the same FIFO
  assign cipher_req_o.in_place = 1'b1; // [RULE_01] [RULE_03]

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  sequence dec_arm_s;
    wr_cmd && dat_i[`CMD_DEC_BIT] && !r.cmd_dec && !dec_busy;
  endsequence

  sequence enc_arm_s;
    wr_cmd && dat_i[`CMD_ENC_BIT] && !r.cmd_enc && !enc_busy;
  endsequence

  sequence dec_finish_s;
    dec_busy && dec_done_i;
  endsequence

  sequence enc_finish_s;
    enc_busy && enc_done_i;
  endsequence

  sequence bus_req_s;
    acc && !ack_o;
  endsequence

  sequence dec_stale_s;
    dec_spent && r.cmd_dec;
  endsequence

  sequence enc_stale_s;
    enc_spent && r.cmd_enc;
  endsequence

  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  dec_start_a: assert property (dec_arm_s |-> ##2 cipher_req_o.decrypt_go) // [RULE_01]
    else $error("decrypt start did not reach the core");

  enc_start_a: assert property (enc_arm_s |-> ##2 cipher_req_o.encrypt_go) // [RULE_02]
    else $error("encrypt start did not reach the core");

  enc_in_place_a: assert property ( // [RULE_03]
    enc_arm_s |-> ##2 (cipher_req_o.encrypt_go && cipher_req_o.in_place))
    else $error("encryption not requested in place");

  dec_done_irq_a: assert property ( // [RULE_04]
    dec_finish_s |-> ##2 r.irq_sts[`IRQ_DEC_BIT])
    else $error("decrypt completion lost");

  enc_done_irq_a: assert property ( // [RULE_04]
    enc_finish_s |-> ##2 r.irq_sts[`IRQ_ENC_BIT])
    else $error("encrypt completion lost");

  set_wins_a: assert property ( // [RULE_04]
    (dec_complete && wr_sts && dat_i[`IRQ_DEC_BIT]) |=> r.irq_sts[`IRQ_DEC_BIT])
    else $error("clear beat a completion event");

  bit_kept_a: assert property ( // [RULE_05]
    (r.cmd_dec && dec_complete && !wr_cmd) |=> r.cmd_dec)
    else $error("hardware dropped decrypt start");

  no_retrigger_a: assert property ( // [RULE_09]
    dec_stale_s |=> (dec_spent && !cipher_req_o.decrypt_go))
    else $error("stale start bit retriggered decryption");

  tx_off_a: assert property ( // [RULE_06]
    (!r.path_on[`TRANSMIT_PATH_ON_BIT] && r.cmd_transmit_path_off) |=> !path_en_o.mod_en)
    else $error("modulation enabled while forced off");

  rx_off_a: assert property ( // [RULE_07]
    (!r.path_on[`RECEIVE_PATH_ON_BIT] && r.cmd_receive_path_off) |=> !path_en_o.demod_en)
    else $error("demodulation enabled while forced off");

  tx_auto_a: assert property ( // [RULE_08]
    (!r.path_on[`TRANSMIT_PATH_ON_BIT] && !r.cmd_transmit_path_off)
      |=> path_en_o.mod_en == $past(modem_tx_req_i))
    else $error("modulation ignores modem control");

  rx_force_a: assert property ( // [RULE_08]
    r.path_on[`RECEIVE_PATH_ON_BIT] |=> path_en_o.demod_en)
    else $error("demodulation not forced on");

  // Bus answer and read data
  ack_answer_a: assert property (bus_req_s |=> ack_o)
    else $error("request left without ack");

  unmapped_zero_a: assert property (
    (bus_req_s && (adr_i > (`ENGINE_STS_OFS | 8'h03))) |=> dat_o == 32'h0)
    else $error("unmapped read returned data");

  cmd_fixed_a: assert property (
    (bus_req_s && hit(adr_i, `CMD_OFS))
      |=> (dat_o[7:6] == `CMD_RSVD_HI && dat_o[3:2] == `CMD_RSVD_LO))
    else $error("command reserved fields read wrong");

  enc_kept_a: assert property ( // [RULE_05]
    (r.cmd_enc && enc_complete && !wr_cmd) |=> r.cmd_enc)
    else $error("hardware dropped encrypt start");

  enc_no_retrigger_a: assert property ( // [RULE_09]
    enc_stale_s |=> (enc_spent && !cipher_req_o.encrypt_go))
    else $error("stale start bit retriggered encryption");

  enc_set_wins_a: assert property ( // [RULE_04]
    (enc_complete && wr_sts && dat_i[`IRQ_ENC_BIT]) |=> r.irq_sts[`IRQ_ENC_BIT])
    else $error("clear beat an encrypt completion");

  dec_sts_clear_a: assert property (
    (wr_sts && dat_i[`IRQ_DEC_BIT] && !dec_complete) |=> !r.irq_sts[`IRQ_DEC_BIT])
    else $error("decrypt status not cleared by write one");

  enc_sts_clear_a: assert property (
    (wr_sts && dat_i[`IRQ_ENC_BIT] && !enc_complete) |=> !r.irq_sts[`IRQ_ENC_BIT])
    else $error("encrypt status not cleared by write one");

  irq_level_a: assert property ( // [RULE_04]
    irq_o == (|(r.irq_sts & r.irq_msk)))
    else $error("interrupt level disagrees with status and mask");

  tx_force_a: assert property ( // [RULE_08]
    r.path_on[`TRANSMIT_PATH_ON_BIT] |=> path_en_o.mod_en)
    else $error("modulation not forced on");

  rx_auto_a: assert property ( // [RULE_08]
    (!r.path_on[`RECEIVE_PATH_ON_BIT] && !r.cmd_receive_path_off)
      |=> path_en_o.demod_en == $past(modem_rx_req_i))
    else $error("demodulation ignores modem control");

  dec_go_single_a: assert property ( // [RULE_01]
    cipher_req_o.decrypt_go |=> !cipher_req_o.decrypt_go)
    else $error("decrypt start pulse too long");

  enc_go_single_a: assert property ( // [RULE_02]
    cipher_req_o.encrypt_go |=> !cipher_req_o.encrypt_go)
    else $error("encrypt start pulse too long");

  // A late done pulse from the core must not fake a completion
  dec_done_idle_a: assert property (
    (!dec_busy && dec_done_i) |=> !dec_complete)
    else $error("decrypt done counted while idle");

  enc_done_idle_a: assert property (
    (!enc_busy && enc_done_i) |=> !enc_complete)
    else $error("encrypt done counted while idle");

  // Clearing a start bit mid-operation does not abort the core
  dec_no_abort_a: assert property (
    (dec_busy && !dec_done_i) |=> dec_busy)
    else $error("decrypt aborted before done");

  enc_no_abort_a: assert property (
    (enc_busy && !enc_done_i) |=> enc_busy)
    else $error("encrypt aborted before done");

endmodule

// ==== hw/mac_cipher_cfg.svh ====
// Register offsets, field positions and reset values of the cipher and path command block
`ifndef MAC_CIPHER_CFG_SVH
`define MAC_CIPHER_CFG_SVH

`define CMD_OFS 8'h00
`define PATH_ON_OFS 8'h04
`define IRQ_STS_OFS 8'h08
`define IRQ_MSK_OFS 8'h0c
`define ENGINE_STS_OFS 8'h10

`define CMD_DEC_BIT 5
`define CMD_ENC_BIT 4
`define CMD_TRANSMIT_PATH_OFF_BIT 1
`define CMD_RECEIVE_PATH_OFF_BIT 0
`define CMD_RSVD_HI 2'h3
`define CMD_RSVD_LO 2'h1
`define CMD_TRANSMIT_PATH_OFF_RESET 1'b1
`define CMD_RECEIVE_PATH_OFF_RESET 1'b1

`define TRANSMIT_PATH_ON_BIT 1
`define RECEIVE_PATH_ON_BIT 0
`define PATH_ON_RESET 2'h0

`define IRQ_DEC_BIT 0
`define IRQ_ENC_BIT 1
`define IRQ_RESET 2'h0

`endif

// ==== hw/mac_cipher_pkg.sv ====
// Types shared by the cipher and path command block
package mac_cipher_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_BUSY = 2'b01,
    SEQ_SPENT = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic decrypt_go;
    logic encrypt_go;
    logic in_place;
  } cipher_req_s;

  typedef struct packed {
    logic mod_en;
    logic demod_en;
  } path_en_s;

endpackage

// ==== hw/cipher_op_seq.sv ====
// One cipher operation: start on a fresh start bit, wait for the core, flag completion
`timescale 1ns/1ps
module cipher_op_seq
  import mac_cipher_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_bit_i,
  input wire logic done_i,
  output logic go_o,
  output logic busy_o,
  output logic spent_o,
  output logic complete_o
);

  typedef struct packed {
    seq_state_e state;
    logic go;
    logic complete;
  } seq_s;

  seq_s s;
  seq_s s_next;

  always_comb begin
    s_next = s;
    s_next.go = 1'b0;
    s_next.complete = 1'b0;
    case (s.state)
      SEQ_IDLE: begin
        if (start_bit_i) begin
          s_next.state = SEQ_BUSY;
          s_next.go = 1'b1;
        end
      end
      SEQ_BUSY: begin
        // Done pulses outside an operation are ignored
        if (done_i) begin
          s_next.state = SEQ_SPENT;
          s_next.complete = 1'b1;
        end
      end
      SEQ_SPENT: begin
        // A bit left set never restarts; it must be seen low first
        if (!start_bit_i) begin
          s_next.state = SEQ_IDLE; // [RULE_09]
        end
      end
      default: begin
        s_next.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{state: SEQ_IDLE, go: 1'b0, complete: 1'b0};
    end else begin
      s <= s_next;
    end
  end

  assign go_o = s.go;
  assign complete_o = s.complete;
  assign busy_o = (s.state == SEQ_BUSY);
  assign spent_o = (s.state == SEQ_SPENT);

endmodule

// ==== hw/path_gate.sv ====
// Enable of one modem path from its on/off pair and the modem's own request
`timescale 1ns/1ps
module path_gate (
  input wire logic on_i,
  input wire logic off_i,
  input wire logic modem_i,
  output logic en_o
);

  // on forces enable, off alone forces disable, neither leaves it to the modem
  assign en_o = on_i | (!off_i & modem_i); // [RULE_08]

endmodule

// ==== test/mac_cipher_path_command_test.sv ====
// Self-checking bench for the cipher and path command register block
`timescale 1ns/1ps
`include "mac_cipher_cfg.svh"
module mac_cipher_path_command_test;
  import mac_cipher_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic dec_done_i = 1'b0;
  logic enc_done_i = 1'b0;
  logic modem_tx_req_i = 1'b0;
  logic modem_rx_req_i = 1'b0;
  cipher_req_s cipher_req_o;
  path_en_s path_en_o;
  logic irq_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_go[2] = '{0, 0};
  logic [31:0] q;
  logic [3:0] bus_sel = 4'h1;

  mac_cipher_path_command DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .dec_done_i(dec_done_i), .enc_done_i(enc_done_i), .modem_tx_req_i(modem_tx_req_i),
    .modem_rx_req_i(modem_rx_req_i), .cipher_req_o(cipher_req_o), .path_en_o(path_en_o),
    .irq_o(irq_o));

  always #20 clk_i = ~clk_i;

  // Start pulses last one cycle, so they are counted rather than caught by timing
  always @(posedge clk_i) begin
    if (cipher_req_o.decrypt_go === 1'b1) n_go[0]++;
    if (cipher_req_o.encrypt_go === 1'b1) n_go[1]++;
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= bus_sel;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic reset_values();
    rd(`CMD_OFS, 32'hc7);
    rd(`PATH_ON_OFS, 32'h0);
    rd(`IRQ_STS_OFS, 32'h0);
    rd(`IRQ_MSK_OFS, 32'h0);
    chk({30'h0, path_en_o}, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
  endtask

  // Tx path walks combos 0..7 while rx walks them in reverse, so the paths must stay apart
  task automatic path_table();
    logic [2:0] t;
    logic [2:0] r;
    for (int i = 0; i < 8; i++) begin
      t = 3'(i);
      r = 3'(7 - i);
      bus(1'b1, `PATH_ON_OFS, {30'h0, t[2], r[2]});
      bus(1'b1, `CMD_OFS, {30'h3, t[1], r[1]});
      @(posedge clk_i);
      modem_tx_req_i <= t[0];
      modem_rx_req_i <= r[0];
      repeat (3) @(posedge clk_i);
      chk({30'h0, path_en_o}, {30'h0, t[2] | (!t[1] & t[0]), r[2] | (!r[1] & r[0])});
    end
    bus(1'b1, `PATH_ON_OFS, 32'h0);
    bus(1'b1, `CMD_OFS, 32'h03);
  endtask

  task automatic pulse_done(input int k);
    @(posedge clk_i);
    if (k == 0) dec_done_i <= 1'b1;
    else enc_done_i <= 1'b1;
    @(posedge clk_i);
    dec_done_i <= 1'b0;
    enc_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // k selects the operation: 0 decrypt, 1 encrypt
  task automatic cipher_op(input int k);
    int n0;
    logic [31:0] sb;
    logic [31:0] cb;
    n0 = n_go[k];
    sb = 32'h1 << k;
    cb = 32'h20 >> k;
    bus(1'b1, `IRQ_MSK_OFS, sb);
    pulse_done(k);
    rd(`IRQ_STS_OFS, 32'h0);
    bus(1'b1, `CMD_OFS, 32'h03 | cb);
    repeat (4) @(posedge clk_i);
    chk(32'(n_go[k]), 32'(n0 + 1));
    chk({31'h0, cipher_req_o.in_place}, 32'h1);
    rd(`ENGINE_STS_OFS, sb);
    pulse_done(k);
    chk({31'h0, irq_o}, 32'h1);
    rd(`IRQ_STS_OFS, sb);
    rd(`CMD_OFS, 32'hc7 | cb);
    repeat (6) @(posedge clk_i);
    chk(32'(n_go[k]), 32'(n0 + 1));
    bus(1'b1, `IRQ_STS_OFS, sb);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, `IRQ_MSK_OFS, 32'h0);
    bus(1'b1, `CMD_OFS, 32'h03);
    bus(1'b1, `CMD_OFS, 32'h03 | cb);
    repeat (4) @(posedge clk_i);
    chk(32'(n_go[k]), 32'(n0 + 2));
    pulse_done(k);
    chk({31'h0, irq_o}, 32'h0);
    rd(`IRQ_STS_OFS, sb);
    bus(1'b1, `IRQ_MSK_OFS, sb);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, `IRQ_STS_OFS, sb);
    bus(1'b1, `IRQ_MSK_OFS, 32'h0);
    bus(1'b1, `CMD_OFS, 32'h03);
  endtask

  task automatic unmapped();
    rd(8'h20, 32'h0);
    bus(1'b1, 8'h20, 32'hff);
    // A write without its byte lane must leave the register alone
    bus_sel = 4'h0;
    bus(1'b1, `CMD_OFS, 32'h30);
    bus_sel = 4'h1;
    rd(`CMD_OFS, 32'hc7);
  endtask

  // Clear and completion meet on one edge; the completion must survive
  task automatic clear_race();
    bus(1'b1, `CMD_OFS, 32'h23);
    repeat (4) @(posedge clk_i);
    fork
      bus(1'b1, `IRQ_STS_OFS, 32'h1);
      pulse_done(0);
    join
    rd(`IRQ_STS_OFS, 32'h1);
    bus(1'b1, `IRQ_STS_OFS, 32'h1);
    bus(1'b1, `CMD_OFS, 32'h03);
    rd(`IRQ_STS_OFS, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    path_table();
    cipher_op(0);
    cipher_op(1);
    unmapped();
    clear_race();
    give_verdict();
  end
endmodule
